// File: hw/rcss_top.sv
`timescale 1ns/1ps
module rcss_top #(
   parameter int LOCK_CYC = rcss_pkg::LOCK_WAIT_CYC,
   parameter logic [31:0] RESET_VECTOR = 32'h0009_0004
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_hw_reset_n,
   input  wire logic [1:0]  i_clk_cfg,
   input  wire logic [2:0]  i_boot_cfg,
   input  wire logic        i_reset_pin_in,
   output logic             o_reset_pin_out,
   output logic             o_reset_pin_oe,
   output logic             o_core_rst,
   output logic             o_core_fetch,
   output logic [31:0]      o_fetch_addr,
   output logic [5:0]       o_pll_mul,
   output logic [1:0]       o_pll_div,
   output logic [2:0]       o_boot_mode,
   input  wire logic [rcss_pkg::ADDR_W-1:0] i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest
);
   import rcss_pkg::*;

   localparam int CW = $clog2(LOCK_CYC + 1);

   // ---------------------------------------------------------------
   // strap decode
   // ---------------------------------------------------------------
   function automatic logic [5:0] ratio_of(input logic [1:0] code);
      case (code)
         CLKCFG_8:  ratio_of = RATIO_8;
         CLKCFG_32: ratio_of = RATIO_32;
         CLKCFG_16: ratio_of = RATIO_16;
         // reserved code falls back to the slowest safe ratio
         default:   ratio_of = RATIO_8;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   rcss_state_e      state_r;
   rcss_state_e      state_nxt;
   logic [CW-1:0]    cnt_r;
   logic [CW-1:0]    cnt_nxt;
   logic [5:0]       mul_r;
   logic [1:0]       div_r;
   logic [1:0]       clkcfg_r;
   logic [2:0]       boot_r;
   logic             runrst_en_r;
   logic             rdv_r;
   logic [31:0]      rdata_r;
   logic             hw_rel;
   logic             lock_done;
   logic             run_rst;
   logic             bus_req;
   logic             wr_pm;
   logic             wr_rr;
   logic [31:0]      rd_mux;

   // a running reset from the pin only counts once the pin is an input
   assign run_rst   = runrst_en_r & ~i_reset_pin_in;
   assign hw_rel    = i_hw_reset_n & ~run_rst;
   assign lock_done = (cnt_r == CW'(LOCK_CYC - 1));

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         RCSS_HOLD: begin
            cnt_nxt = '0;
            if (hw_rel) begin
               state_nxt = RCSS_LOCK;
            end
         end
         RCSS_LOCK: begin
            cnt_nxt = cnt_r + CW'(1);
            if (!hw_rel) begin
               state_nxt = RCSS_HOLD;
            end else if (lock_done) begin
               state_nxt = RCSS_RUN;
            end
         end
         RCSS_RUN: begin
            if (!hw_rel) begin
               state_nxt = RCSS_HOLD;
            end
         end
         default: state_nxt = RCSS_HOLD;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r <= RCSS_HOLD;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // straps are caught in the cycle reset is released
   wire strap_take = (state_r == RCSS_HOLD) & hw_rel;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         clkcfg_r <= CLKCFG_8;
         boot_r   <= 3'h0;
      end else if (strap_take) begin
         clkcfg_r <= i_clk_cfg;
         boot_r   <= i_boot_cfg;
      end
   end

   // ---------------------------------------------------------------
   // avalon slave, one wait cycle per access
   // ---------------------------------------------------------------
   assign bus_req = (i_avs_read | i_avs_write) & ~rdv_r;
   assign wr_pm   = i_avs_write & rdv_r & (i_avs_address == ADDR_PWRCTL_OFS)
                    & (state_r == RCSS_RUN);
   assign wr_rr   = i_avs_write & rdv_r
                    & (i_avs_address == ADDR_RUNRST_OFS);

   always_comb begin
      rd_mux = BUS_UNMAPPED;
      case (i_avs_address)
         ADDR_PWRCTL_OFS: begin
            rd_mux = '0;
            rd_mux[PM_MUL_LSB +: PM_MUL_W] = mul_r;
            rd_mux[PM_DIV_LSB +: PM_DIV_W] = div_r;
         end
         ADDR_RUNRST_OFS: begin
            rd_mux = '0;
            rd_mux[RUNRST_EN_BIT] = runrst_en_r;
         end
         ADDR_STATUS_OFS: begin
            rd_mux = '0;
            rd_mux[ST_RUN_BIT] = (state_r == RCSS_RUN);
            rd_mux[ST_CLKCFG_LSB +: 2] = clkcfg_r;
            rd_mux[ST_BOOT_LSB +: 3] = boot_r;
         end
         default: rd_mux = BUS_UNMAPPED;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rdv_r   <= 1'b0;
         rdata_r <= '0;
      end else begin
         rdv_r   <= bus_req;
         rdata_r <= rd_mux;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         mul_r       <= RATIO_8;
         div_r       <= PM_DIV_RST;
         runrst_en_r <= 1'b0;
      end else begin
         if (state_r == RCSS_HOLD) begin
            mul_r <= ratio_of(i_clk_cfg);
            div_r <= PM_DIV_RST;
         end else if (wr_pm && i_avs_byteenable[0]) begin
            mul_r <= i_avs_writedata[PM_MUL_LSB +: PM_MUL_W];
         end
         if (wr_pm && i_avs_byteenable[1]) begin
            div_r <= i_avs_writedata[PM_DIV_LSB +: PM_DIV_W];
         end
         if (!i_hw_reset_n) begin
            runrst_en_r <= 1'b0;
         end else if (wr_rr && i_avs_byteenable[0]) begin
            runrst_en_r <= i_avs_writedata[RUNRST_EN_BIT];
         end
      end
   end

   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~rdv_r;
   assign o_avs_readdata    = rdata_r;

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic core_rst_r;
   logic fetch_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         core_rst_r <= 1'b1;
         fetch_r    <= 1'b0;
      end else begin
         core_rst_r <= (state_nxt != RCSS_RUN);
         fetch_r    <= (state_r == RCSS_LOCK) & (state_nxt == RCSS_RUN);
      end
   end

   assign o_core_rst      = core_rst_r;
   assign o_core_fetch    = fetch_r;
   assign o_fetch_addr    = RESET_VECTOR;
   assign o_pll_mul       = mul_r;
   assign o_pll_div       = div_r;
   assign o_boot_mode     = boot_r;
   // pin shows the core reset (active low) unless it serves as an input
   assign o_reset_pin_out = ~core_rst_r;
   assign o_reset_pin_oe  = ~runrst_en_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb_chk @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   // cycles spent in the lock wait, counted apart from the sequencer
   // so that a slip in the sequencer count cannot hide itself
   logic [CW-1:0] chk_cnt_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || (state_r != RCSS_LOCK)) begin
         chk_cnt_r <= '0;
      end else begin
         chk_cnt_r <= chk_cnt_r + CW'(1);
      end
   end

   sequence s_rel;
      (state_r == RCSS_HOLD) ##1 (state_r == RCSS_LOCK);
   endsequence

   sequence s_leave_rst;
      o_core_rst ##1 !o_core_rst;
   endsequence

   // lock wait and core release
   // needs a lock wait of at least the eight cycles watched here
   a_lock_wait_len: assert property (
      s_rel ##0 (hw_rel [*8]) |-> o_core_rst)
      else $error("core left reset before lock wait");
   a_lock_count: assert property (
      $rose(o_core_fetch) |-> $past(chk_cnt_r) == CW'(LOCK_CYC - 1))
      else $error("lock wait length wrong");
   a_hold_in_rst: assert property (
      !i_hw_reset_n |=> o_core_rst)
      else $error("core not held in reset");
   a_no_fetch_held: assert property (
      o_core_rst |-> !o_core_fetch)
      else $error("fetch while core in reset");
   a_fetch_vector: assert property (
      $fell(o_core_rst) |-> o_core_fetch && o_fetch_addr == RESET_VECTOR)
      else $error("fetch not started at reset vector");
   a_fetch_leave: assert property (
      s_leave_rst |-> o_core_fetch ##1 !o_core_fetch)
      else $error("fetch is not a single pulse");

   // dual-purpose pin
   a_pin_default: assert property (
      $past(i_rst) |-> o_reset_pin_oe)
      else $error("reset pin not an output after reset");
   a_pin_drive: assert property (
      o_reset_pin_oe |-> o_reset_pin_out == !o_core_rst)
      else $error("reset pin output disagrees with core reset");
   a_hw_pin_out: assert property (
      !i_hw_reset_n |=> o_reset_pin_oe)
      else $error("hardware reset left the pin as an input");
   a_pin_input: assert property (
      wr_rr && i_avs_byteenable[0] && i_hw_reset_n |=>
      o_reset_pin_oe == !$past(i_avs_writedata[RUNRST_EN_BIT]))
      else $error("pin direction disagrees with control write");
   a_run_rst_in: assert property (
      !o_reset_pin_oe && !i_reset_pin_in |=> o_core_rst)
      else $error("running reset ignored");

   // pll fields and straps
   a_ratio_decode: assert property (
      state_r == RCSS_HOLD && i_clk_cfg == CLKCFG_32 |=>
      o_pll_mul == RATIO_32)
      else $error("strap ratio decode wrong");
   a_pm_write: assert property (
      wr_pm && i_avs_byteenable[1] |=>
      o_pll_div == $past(i_avs_writedata[PM_DIV_LSB +: PM_DIV_W]))
      else $error("pll divider write lost");
   a_mul_write: assert property (
      wr_pm && i_avs_byteenable[0] |=>
      o_pll_mul == $past(i_avs_writedata[PM_MUL_LSB +: PM_MUL_W]))
      else $error("pll multiplier write lost");
   a_pm_lock_hold: assert property (
      state_r == RCSS_LOCK |=> $stable(o_pll_div))
      else $error("pll divider moved during lock wait");
   a_strap_hold: assert property (
      strap_take |=> o_boot_mode == $past(i_boot_cfg))
      else $error("boot straps not captured at release");
   a_boot_stable: assert property (
      state_r != RCSS_HOLD |=> $stable(o_boot_mode))
      else $error("boot straps moved outside reset");
endmodule

// File: hw/rcss_pkg.sv
// How it works
// - straps 00/01/10 give core ratio 8:1/32:1/16:1 and 11 is reserved.
// - once running, software may rewrite the pll multiplier and divider.
// - after hardware reset release the pll lock wait lasts 4096 ref cycles.
// - when the lock wait ends the core fetches from the fixed reset vector.
// - after reset the dual-purpose reset pin is driven as a reset output.
// - the pin is a running-reset input only while control bit 0 is set.
package rcss_pkg;
   // ---------------------------------------------------------------
   // register map, one aligned word each
   // ---------------------------------------------------------------
   localparam logic [3:0]  ADDR_PWRCTL_OFS = 4'h0;
   localparam logic [3:0]  ADDR_RUNRST_OFS = 4'h4;
   localparam logic [3:0]  ADDR_STATUS_OFS = 4'h8;
   localparam int          ADDR_W          = 4;

   // power management control fields
   localparam int          PM_MUL_LSB      = 0;
   localparam int          PM_MUL_W        = 6;
   localparam int          PM_DIV_LSB      = 8;
   localparam int          PM_DIV_W        = 2;
   localparam logic [1:0]  PM_DIV_RST      = 2'h0;

   // running reset control
   localparam int          RUNRST_EN_BIT   = 0;

   // status fields
   localparam int          ST_RUN_BIT      = 0;
   localparam int          ST_CLKCFG_LSB   = 4;
   localparam int          ST_BOOT_LSB     = 8;

   // ---------------------------------------------------------------
   // strap codes and ratios
   // ---------------------------------------------------------------
   localparam logic [1:0]  CLKCFG_8        = 2'h0;
   localparam logic [1:0]  CLKCFG_32       = 2'h1;
   localparam logic [1:0]  CLKCFG_16       = 2'h2;
   localparam logic [5:0]  RATIO_8         = 6'h08;
   localparam logic [5:0]  RATIO_16        = 6'h10;
   localparam logic [5:0]  RATIO_32        = 6'h20;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          LOCK_WAIT_CYC   = 4096;
   localparam logic [31:0] BUS_UNMAPPED    = 32'hdead_0bad;

   typedef enum logic [1:0] {
      RCSS_HOLD,
      RCSS_LOCK,
      RCSS_RUN
   } rcss_state_e;
endpackage

// File: dv/rcss_board.sv
`timescale 1ns/1ps
module rcss_board (
   input  wire logic       i_clk_sys,
   input  wire logic       i_hold_rst,
   input  wire logic [1:0] i_clk_sel,
   input  wire logic [2:0] i_boot_sel,
   input  wire logic       i_pull_low,
   input  wire logic       i_pin_out,
   input  wire logic       i_pin_oe,
   output logic            o_hw_reset_n,
   output logic [1:0]      o_clk_cfg,
   output logic [2:0]      o_boot_cfg,
   output logic            o_pin_level
);
   // power comes up with reset low
   initial o_hw_reset_n = 1'b0;
   initial o_clk_cfg = 2'h0;
   initial o_boot_cfg = 3'h0;

   // straps freeze once a reset is requested, so they are settled before
   // reset falls and cannot move until it is released
   always @(posedge i_clk_sys) begin
      if (!i_hold_rst) begin
         o_clk_cfg <= i_clk_sel;
         o_boot_cfg <= i_boot_sel;
      end
      o_hw_reset_n <= !i_hold_rst;
   end

   // pin has a pull-up, so an undriven wire reads high
   assign o_pin_level = i_pin_oe ? i_pin_out : !i_pull_low;
endmodule

// File: dv/reset_clock_startup_seq_bench.sv
`timescale 1ns/1ps
module reset_clock_startup_seq_bench;
   import rcss_pkg::*;
   localparam int LOCK = 16;
   localparam logic [5:0] RAT [4] = '{RATIO_8, RATIO_32, RATIO_16, RATIO_8};
   logic clk, rst, hold, pull, rd, wr, hw_n, pin_lvl;
   logic pin_out, pin_oe, core_rst, fetch, waitreq;
   logic [1:0]  sel, cfg, div;
   logic [2:0]  bsel, boot, bmode;
   logic [3:0]  adr, be;
   logic [5:0]  mul;
   logic [31:0] wd, rdata, faddr, d;
   int err_count, total_checks, cyc, n;

   rcss_board u_board (.i_clk_sys(clk), .i_hold_rst(hold), .i_clk_sel(sel),
      .i_boot_sel(bsel), .i_pull_low(pull), .i_pin_out(pin_out),
      .i_pin_oe(pin_oe), .o_hw_reset_n(hw_n), .o_clk_cfg(cfg),
      .o_boot_cfg(boot), .o_pin_level(pin_lvl));
   rcss_top #(.LOCK_CYC(LOCK)) u_dut (.i_clk_sys(clk), .i_rst(rst),
      .i_hw_reset_n(hw_n), .i_clk_cfg(cfg), .i_boot_cfg(boot),
      .i_reset_pin_in(pin_lvl), .o_reset_pin_out(pin_out),
      .o_reset_pin_oe(pin_oe), .o_core_rst(core_rst), .o_core_fetch(fetch),
      .o_fetch_addr(faddr), .o_pll_mul(mul), .o_pll_div(div),
      .o_boot_mode(bmode), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("errors %0d checks %0d", err_count, total_checks);
      if (err_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // waitrequest and read data are looked at mid-cycle, so the value
   // seen is the one that stands at the next rising edge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] v,
            input logic [3:0] m = 4'hf);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= v;
      be <= m;
      @(negedge clk);
      while (waitreq !== 1'b0) @(negedge clk);
      d = rdata;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // edges from the stimulus edge until the release pulse is seen
   task wait_fetch;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (fetch !== 1'b1 && n < 100);
   endtask

   // reference clock never stops
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, hold, pull, rd, wr, sel, bsel, adr, wd} = {3'b110, 2'b00, 41'h0};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check(core_rst, 1'b1);
      check({pin_oe, pin_out}, 2'b10);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         sel <= 2'(k);
         bsel <= 3'(k * 3);
         @(posedge clk);
         hold <= 1'b1;
         repeat (3) @(posedge clk);
         #1;
         check(core_rst, 1'b1);
         check(mul, RAT[k]);
         bus(1'b1, ADDR_PWRCTL_OFS, 32'h3f); // refused while in reset
         @(posedge clk);
         hold <= 1'b0;
         wait_fetch();
         check(32'(n), 32'(LOCK + 2));
         check({core_rst, pin_out}, 2'b01);
         check(faddr, 32'h0009_0004);
         check({bmode, mul}, {3'(k * 3), RAT[k]});
         @(posedge clk);
         #1;
         check(fetch, 1'b0);
         bus(1'b0, ADDR_STATUS_OFS, 32'h0);
         check(d & 32'h731, {21'h0, 3'(k * 3), 2'h0, 2'(k), 4'h1});
      end
      bus(1'b1, ADDR_PWRCTL_OFS, 32'h205);
      bus(1'b0, ADDR_PWRCTL_OFS, 32'h0);
      check(d & 32'h33f, 32'h205);
      check({div, mul}, 8'h85);
      bus(1'b1, ADDR_PWRCTL_OFS, 32'h13f, 4'h2);
      #1;
      check({div, mul}, 8'h45);
      bus(1'b0, 4'hc, 32'h0);
      check(d, BUS_UNMAPPED);
      bus(1'b1, ADDR_RUNRST_OFS, 32'h1);
      @(posedge clk);
      #1;
      check(pin_oe, 1'b0);
      @(posedge clk);
      pull <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(core_rst, 1'b1);
      @(posedge clk);
      pull <= 1'b0;
      wait_fetch();
      check(32'(n), 32'(LOCK + 1));
      @(posedge clk);
      hold <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check({pin_oe, core_rst}, 2'b11);
      tally_and_finish();
   end
endmodule
